// ---- design/pblp_defs.svh ----
// Constants for the buffer link port: offsets, reset values, field bits.
// Assumes it is included by the package and by the top module only.
`ifndef PBLP_DEFS_SVH
`define PBLP_DEFS_SVH

// ==========================================
// Register map
`define PBLP_OFS_CTRL   8'h00
`define PBLP_OFS_ACK    8'h04
`define PBLP_OFS_RSTAT  8'h08
`define PBLP_OFS_REWIND 8'h0c
`define PBLP_OFS_STATUS 8'h10
`define PBLP_CTRL_RST   5'h10

// ==========================================
// Stream fields
`define PBLP_KEEP_ALL   8'hff
`define PBLP_USR_ABORT  0
`define PBLP_USR_CRF    1
`define PBLP_MASK_SHORT 6'h1f
`define PBLP_MASK_LONG  6'h3f

`endif

// ---- design/pblp_pkg.sv ----
// Types shared by the buffer link port.
// Assumes the constants header sits beside it.
package pblp_pkg;
  `include "pblp_defs.svh"

  typedef struct packed {
    logic [63:0] data;
    logic [7:0]  keep;
    logic        last;
    logic [7:0]  user;
  } pblp_beat_type;

  typedef struct packed {
    logic pll_rst;
    logic long_mode;
    logic crf_en;
    logic host;
    logic master_en;
  } pblp_ctrl_type;

  typedef struct packed {
    logic [8:0] rsvd;
    logic [7:0] abort_cnt;
    logic       qlock;
    logic       plock;
    logic       flow;
    logic [5:0] buf_stat;
    logic [5:0] next_id;
  } pblp_status_type;

  typedef struct packed {
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    pblp_ctrl_type ctrl;
    logic [5:0]    last_ack;
    logic [5:0]    rcvd_stat;
    logic [5:0]    next_id;
    logic          rewind;
    logic [7:0]    abort_cnt;
    logic          plock_s1;
    logic          plock_s2;
    logic          qlock_s1;
    logic          qlock_s2;
    pblp_beat_type rx;
    logic          rx_valid;
    logic          rx_first;
    logic          tx_ready;
    logic          tx_first;
  } pblp_st_type;
endpackage : pblp_pkg

// ---- design/pblp_port.sv ----
// Link-side port between packet buffer and physical layer.
// Assumes APB master on pclk, buffer logic on pclk,
// PLL lock levels from other domains.
`timescale 1ns/1ps
`include "pblp_defs.svh"

module pblp_port (
  // Clock, reset, enable
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    ce,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  // Transmit stream from buffer
  input  wire logic                    tx_valid,
  output logic                         tx_ready,
  input  wire pblp_pkg::pblp_beat_type tx_beat,
  // Receive stream toward buffer
  output logic                         rx_valid,
  input  wire logic                    rx_ready,
  output pblp_pkg::pblp_beat_type      rx_beat,
  // Link state toward buffer
  output logic                         master_enable,
  output logic                         host_mode,
  output logic                         long_symbol_mode,
  output logic                         rewind_request,
  output logic [5:0]                   next_send_identifier,
  output logic [5:0]                   last_ack_identifier,
  output logic [5:0]                   partner_buffer_status,
  // State from buffer
  input  wire logic [5:0]              local_buffer_status,
  input  wire logic                    tx_flow_control,
  // Shared PLL hookups
  input  wire logic                    pll0_clk,
  input  wire logic                    pll0_refclk,
  input  wire logic                    pll1_clk,
  input  wire logic                    pll1_refclk,
  input  wire logic                    pll0_locked,
  input  wire logic                    quad_pll_clock,
  input  wire logic                    quad_pll_refclk,
  input  wire logic                    quad_pll_locked,
  output logic                         shared_pll_reset
);
  import pblp_pkg::*;

  // ==========================================
  // State
  pblp_st_type     q;
  pblp_st_type     d;
  pblp_status_type stat;
  logic [5:0]      id_mask;
  logic            setup;
  logic            acc;
  logic            tx_fire;
  logic            rx_fire;
  logic            mapped;

  // Identifier width follows the symbol mode
  assign id_mask = q.ctrl.long_mode ? `PBLP_MASK_LONG : `PBLP_MASK_SHORT;
  assign setup   = psel && !penable && !q.pready;
  assign acc     = psel && penable && q.pready;
  assign tx_fire = tx_valid && q.tx_ready;
  assign rx_fire = q.rx_valid && rx_ready;
  assign mapped  = (paddr == `PBLP_OFS_CTRL) || (paddr == `PBLP_OFS_ACK) ||
                   (paddr == `PBLP_OFS_RSTAT) || (paddr == `PBLP_OFS_REWIND) ||
                   (paddr == `PBLP_OFS_STATUS);

  always_comb begin
    stat           = '0;
    stat.abort_cnt = q.abort_cnt;
    stat.qlock     = q.qlock_s2;
    stat.plock     = q.plock_s2;
    stat.flow      = tx_flow_control;
    stat.buf_stat  = local_buffer_status;
    stat.next_id   = q.next_id;
  end

  // ==========================================
  // Next state
  always_comb begin
    d          = q;
    d.rewind   = 1'b0;
    d.pready   = 1'b0;
    d.pslverr  = 1'b0;
    // Lock levels cross from the PLL domains
    d.plock_s1 = pll0_locked;
    d.plock_s2 = q.plock_s1;
    d.qlock_s1 = quad_pll_locked;
    d.qlock_s2 = q.qlock_s1;

    // Receive side drains; one-beat hold keeps ready a flop
    if (rx_fire) begin
      d.rx_valid = 1'b0;
      d.tx_ready = 1'b1;
    end
    // Beats loop back; half rate traded for flop-driven ready
    if (tx_fire) begin
      d.rx_valid = 1'b1;
      d.tx_ready = 1'b0;
      d.rx_first = q.tx_first;
      d.tx_first = tx_beat.last;
      d.rx.data  = tx_beat.data;
      d.rx.last  = tx_beat.last;
      d.rx.keep  = tx_beat.last ? tx_beat.keep : `PBLP_KEEP_ALL;
      d.rx.user  = '0;
      if (q.tx_first && q.ctrl.crf_en) begin
        d.rx.user[`PBLP_USR_CRF] = tx_beat.user[`PBLP_USR_CRF];
      end
      if (tx_beat.last) begin
        if (tx_beat.user[`PBLP_USR_ABORT]) begin
          // Aborted packet is dropped downstream, id not consumed
          d.rx.user[`PBLP_USR_ABORT] = 1'b1;
          d.abort_cnt = q.abort_cnt + 8'h01;
        end else begin
          d.next_id = (q.next_id + 6'h01) & id_mask;
        end
      end
    end

    // APB: answer one cycle after setup
    if (setup) begin
      d.pready  = 1'b1;
      d.pslverr = !mapped;
      d.prdata  = '0;
      if (!pwrite) begin
        case (paddr)
          `PBLP_OFS_CTRL:   d.prdata = {27'h0000000, q.ctrl};
          `PBLP_OFS_ACK:    d.prdata = {26'h0000000, q.last_ack};
          `PBLP_OFS_RSTAT:  d.prdata = {26'h0000000, q.rcvd_stat};
          `PBLP_OFS_REWIND: d.prdata = {26'h0000000, q.next_id};
          `PBLP_OFS_STATUS: d.prdata = stat;
          default:          d.prdata = '0;
        endcase
      end
    end
    if (acc && pwrite) begin
      case (paddr)
        `PBLP_OFS_CTRL:   d.ctrl = pblp_ctrl_type'(pwdata[4:0]);
        `PBLP_OFS_ACK:    d.last_ack = pwdata[5:0] & id_mask;
        `PBLP_OFS_RSTAT:  d.rcvd_stat = pwdata[5:0];
        `PBLP_OFS_REWIND: begin
          // Rewind wins over a packet ending in the same cycle
          d.next_id = pwdata[5:0] & id_mask;
          d.rewind  = 1'b1;
        end
        default: d.rewind = q.rewind & 1'b0;
      endcase
    end
    // A drop to short mode must not leave a stale sixth identifier bit
    if (!d.ctrl.long_mode) begin
      d.next_id  = d.next_id & `PBLP_MASK_SHORT;
      d.last_ack = d.last_ack & `PBLP_MASK_SHORT;
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q          <= '0;
      q.ctrl     <= pblp_ctrl_type'(`PBLP_CTRL_RST);
      q.tx_ready <= 1'b1;
      q.tx_first <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  // ==========================================
  // Outputs
  assign pready                = q.pready;
  assign prdata                = q.prdata;
  assign pslverr               = q.pslverr;
  assign tx_ready              = q.tx_ready;
  assign rx_valid              = q.rx_valid;
  assign rx_beat               = q.rx;
  assign master_enable         = q.ctrl.master_en;
  assign host_mode             = q.ctrl.host;
  assign long_symbol_mode      = q.ctrl.long_mode;
  assign rewind_request        = q.rewind;
  assign next_send_identifier  = q.next_id;
  assign last_ack_identifier   = q.last_ack;
  assign partner_buffer_status = q.rcvd_stat;
  assign shared_pll_reset      = q.ctrl.pll_rst;

  // ==========================================
  // Checks
  a_keep_full: assert property (@(posedge pclk) disable iff (!presetn)
    q.rx_valid && !q.rx.last |-> q.rx.keep == `PBLP_KEEP_ALL)
    else $error("receive beat not full before last");

  a_beat_hold: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    q.rx_valid && !rx_ready |=> q.rx_valid && $stable(q.rx))
    else $error("receive beat changed before taken");

  a_ready_drop: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    tx_fire |=> !q.tx_ready && q.rx_valid)
    else $error("transmit beat not held after accept");

  a_crf_first: assert property (@(posedge pclk) disable iff (!presetn)
    q.rx_valid && q.rx.user[`PBLP_USR_CRF] |-> q.rx_first)
    else $error("critical flag off first beat");

  a_abort_count: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    tx_fire && tx_beat.last && tx_beat.user[`PBLP_USR_ABORT]
    |=> q.abort_cnt == $past(q.abort_cnt) + 8'h01 && q.rx.user[`PBLP_USR_ABORT])
    else $error("aborted packet not counted");

  a_next_step: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    tx_fire && tx_beat.last && !tx_beat.user[`PBLP_USR_ABORT] && !(acc && pwrite)
    |=> q.next_id == (($past(q.next_id) + 6'h01) & $past(id_mask)))
    else $error("next identifier did not step");

  a_id_short: assert property (@(posedge pclk) disable iff (!presetn)
    !q.ctrl.long_mode && !$past(q.ctrl.long_mode) |-> !q.next_id[5])
    else $error("short identifier overflowed");

  a_rewind_pulse: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    acc && pwrite && paddr == `PBLP_OFS_REWIND
    |=> q.rewind ##1 !q.rewind)
    else $error("rewind not a single pulse");

  a_ack_write: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    acc && pwrite && paddr == `PBLP_OFS_ACK
    |=> q.last_ack == ($past(pwdata[5:0]) & $past(id_mask)))
    else $error("acknowledged identifier not stored");

  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    setup |=> q.pready ##1 !q.pready)
    else $error("bus answer not one cycle");

  // ==========================================
  // Register bus checks
  a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    acc && pwrite && paddr == `PBLP_OFS_CTRL |=> q.ctrl == $past(pwdata[4:0]))
    else $error("control word not stored");

  a_master_follow: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    acc && pwrite && paddr == `PBLP_OFS_CTRL |=> master_enable == $past(pwdata[0]))
    else $error("master enable not driven");

  a_host_follow: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    acc && pwrite && paddr == `PBLP_OFS_CTRL |=> host_mode == $past(pwdata[1]))
    else $error("host bit not driven");

  a_rstat_write: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    acc && pwrite && paddr == `PBLP_OFS_RSTAT |=> q.rcvd_stat == $past(pwdata[5:0]))
    else $error("partner status not stored");

  a_rewind_load: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    acc && pwrite && paddr == `PBLP_OFS_REWIND |=> q.next_id == ($past(pwdata[5:0]) & $past(id_mask)))
    else $error("rewind identifier not loaded");

  a_rewind_only: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    !(acc && pwrite && paddr == `PBLP_OFS_REWIND) |=> !q.rewind)
    else $error("rewind without request");

  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    setup && !mapped |=> q.pslverr)
    else $error("unmapped access not refused");

  a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    setup && mapped |=> !q.pslverr)
    else $error("mapped access refused");

  a_rdata_write: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    setup && pwrite |=> q.prdata == '0)
    else $error("read data on write");

  a_read_ack: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    setup && !pwrite && paddr == `PBLP_OFS_ACK |=> q.prdata == 32'($past(q.last_ack)))
    else $error("acknowledged identifier read wrong");

  a_read_ctrl: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    setup && !pwrite && paddr == `PBLP_OFS_CTRL |=> q.prdata == 32'($past(q.ctrl)))
    else $error("control read wrong");

  a_read_aborts: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    setup && !pwrite && paddr == `PBLP_OFS_STATUS |=> q.prdata[22:15] == $past(q.abort_cnt))
    else $error("abort count read wrong");

  a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    !psel |=> !q.pready)
    else $error("answer without select");

  // ==========================================
  // Stream checks
  a_rx_clear: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    rx_fire |=> !q.rx_valid && q.tx_ready)
    else $error("receive beat not released");

  a_ready_excl: assert property (@(posedge pclk) disable iff (!presetn)
    q.rx_valid |-> !q.tx_ready)
    else $error("ready while beat pending");

  a_user_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
    q.rx_valid |-> q.rx.user[7:2] == '0)
    else $error("reserved sideband bits set");

  a_abort_last: assert property (@(posedge pclk) disable iff (!presetn)
    q.rx_valid && q.rx.user[`PBLP_USR_ABORT] |-> q.rx.last)
    else $error("abort off last beat");

  a_data_pass: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    tx_fire |=> q.rx.data == $past(tx_beat.data))
    else $error("beat data altered");

  a_last_pass: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    tx_fire |=> q.rx.last == $past(tx_beat.last))
    else $error("beat end marker altered");

  a_keep_last: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    tx_fire && tx_beat.last |=> q.rx.keep == $past(tx_beat.keep))
    else $error("last beat lanes altered");

  a_abort_hold: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    tx_fire && tx_beat.last && tx_beat.user[`PBLP_USR_ABORT] && !(acc && pwrite)
    |=> q.next_id == $past(q.next_id))
    else $error("aborted packet used identifier");

  a_count_hold: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    !(tx_fire && tx_beat.last && tx_beat.user[`PBLP_USR_ABORT]) |=> q.abort_cnt == $past(q.abort_cnt))
    else $error("abort count moved");

  a_crf_gate: assert property (@(posedge pclk) disable iff (!presetn || !ce)
    tx_fire && !q.ctrl.crf_en |=> !q.rx.user[`PBLP_USR_CRF])
    else $error("critical flag while disabled");

  a_ack_mask: assert property (@(posedge pclk) disable iff (!presetn)
    !q.ctrl.long_mode |-> !q.last_ack[5])
    else $error("short acknowledged identifier overflowed");

endmodule : pblp_port

// ---- testbench/pblp_buf_model.sv ----
// Packet buffer model on the buffer side of the port.
// Assumes one pclk domain and an active-low async reset.
`timescale 1ns/1ps
module pblp_buf_model (
  // Clock, reset, pacing
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    slow,
  // Receive stream from the port
  input  wire logic                    rx_valid,
  input  wire pblp_pkg::pblp_beat_type rx_beat,
  output logic                         rx_ready,
  // Buffer state toward the port; drop count toward the bench
  output logic [5:0]                   local_buffer_status,
  output logic                         tx_flow_control,
  output logic [7:0]                   dropped
);
  import pblp_pkg::*;
  logic [5:0] free_slots;
  // ==========================================
  // Sink with optional stalls
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ready            <= 1'b0;
      local_buffer_status <= 6'h1e;
      tx_flow_control     <= 1'b0;
      dropped             <= 8'h00;
    end else begin
      rx_ready        <= slow ? 1'($urandom_range(1)) : 1'b1;
      tx_flow_control <= slow;
      if (rx_valid && rx_ready && rx_beat.last) begin
        // Estimate moves only when a packet lands, so register reads stay stable
        free_slots = 6'($urandom_range(40));
        local_buffer_status <= (free_slots > 6'd30) ? 6'd30 : free_slots;
        if (rx_beat.user[0]) dropped <= dropped + 8'h01;
      end
    end
  end
endmodule : pblp_buf_model

// ---- testbench/pblp_port_tb.sv ----
// Self-checking bench for the buffer link port.
// Assumes the package, the port and the buffer model are compiled first.
`timescale 1ns/1ps
module pblp_port_tb;
  import pblp_pkg::*;
  // ==========================================
  // Signals
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, e, slow, locks, pll_ck, ce;
  logic          tx_valid, tx_ready, rx_valid, rx_ready, master_enable, host_mode, long_symbol_mode;
  logic          rewind_request, tx_flow_control, shared_pll_reset;
  logic [7:0]    paddr, dropped;
  logic [31:0]   pwdata, prdata, rd;
  logic [5:0]    next_send_identifier, last_ack_identifier, partner_buffer_status, local_buffer_status;
  pblp_beat_type tx_beat, rx_beat, b, q[$];
  int            err_total, checks_done, rw_cnt;
  // One fixed link rate; the same clock serves the register side
  always #4 pclk = ~pclk;
  // No half-rate domain inside; shared clocks only tie to one source
  always #5 pll_ck = ~pll_ck;
  pblp_port dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_beat(tx_beat), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_beat(rx_beat),
    .master_enable(master_enable), .host_mode(host_mode), .long_symbol_mode(long_symbol_mode),
    .rewind_request(rewind_request), .next_send_identifier(next_send_identifier),
    .last_ack_identifier(last_ack_identifier), .partner_buffer_status(partner_buffer_status),
    .local_buffer_status(local_buffer_status), .tx_flow_control(tx_flow_control), .pll0_clk(pll_ck),
    .pll0_refclk(pll_ck), .pll1_clk(pll_ck), .pll1_refclk(pll_ck), .pll0_locked(locks),
    .quad_pll_clock(pll_ck), .quad_pll_refclk(pll_ck), .quad_pll_locked(locks),
    .shared_pll_reset(shared_pll_reset));
  pblp_buf_model buf_model (.pclk(pclk), .presetn(presetn), .slow(slow), .rx_valid(rx_valid),
    .rx_beat(rx_beat), .rx_ready(rx_ready), .local_buffer_status(local_buffer_status),
    .tx_flow_control(tx_flow_control), .dropped(dropped));
  // ==========================================
  // Compare, bus and stream tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_beat(input pblp_beat_type got, input pblp_beat_type exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: beat %h expected %h", $time, got, exp);
    end
  endtask : chk_beat
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) err_total++;
    r = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic send(input pblp_beat_type x, input logic first);
    pblp_beat_type ex;
    int n;
    ex = x;
    n = 0;
    if (!x.last) ex.keep = 8'hff;
    ex.user = {6'h00, first & x.user[1], x.last & x.user[0]};
    @(posedge pclk);
    tx_valid <= 1'b1;
    tx_beat  <= x;
    do begin
      @(posedge pclk);
      n++;
    end while (tx_ready !== 1'b1 && n < 20);
    if (tx_ready !== 1'b1) err_total++;
    q.push_back(ex);
    tx_valid <= 1'b0;
  endtask : send
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================
  // Result monitor: oldest note against each delivered beat
  always @(posedge pclk) begin
    if (presetn && rewind_request === 1'b1) rw_cnt++;
    if (presetn && rx_valid === 1'b1 && rx_ready === 1'b1) begin
      chk(32'(q.size() != 0), 32'h1);
      if (q.size() != 0) chk_beat(rx_beat, q.pop_front());
    end
  end
  initial begin
    #(8 * 20000);
    err_total++;
    report_and_stop();
  end
  // ==========================================
  // Main sequence
  initial begin
    {pclk, pll_ck, presetn, psel, penable, pwrite, tx_valid, slow, locks} = '0;
    {paddr, pwdata, tx_beat, err_total, checks_done, rw_cnt} = '0;
    ce = 1'b1;
    void'($urandom(32'hcbf4));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'({tx_ready, shared_pll_reset, master_enable, next_send_identifier}), 32'h180);
    apb(1'b0, 8'h00, 32'h0, rd, e);
    chk(rd, 32'h10);
    apb(1'b1, 8'h00, 32'h0f, rd, e);
    locks <= 1'b1;
    @(posedge pclk);
    chk(32'({master_enable, host_mode, long_symbol_mode, shared_pll_reset}), 32'he);
    apb(1'b1, 8'h04, 32'h2a, rd, e);
    apb(1'b1, 8'h08, 32'h15, rd, e);
    @(posedge pclk);
    chk(32'({last_ack_identifier, partner_buffer_status}), 32'({6'h2a, 6'h15}));
    apb(1'b1, 8'h0c, 32'h3e, rd, e);
    apb(1'b0, 8'h0c, 32'h0, rd, e);
    chk(rd, 32'h3e);
    slow <= 1'b1;
    // Four 3-beat packets, the third aborted; long ids wrap past 63
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 3; j++) begin
        b.data = {$urandom, $urandom};
        b.keep = (j == 2) ? 8'($urandom_range(255, 1)) : 8'hff;
        b.last = (j == 2);
        b.user = {6'h00, (j == 0) & k[0], (j == 2) & (k == 2)};
        send(b, j == 0);
      end
    end
    for (int n = 0; n < 200 && q.size() > 0; n++) @(posedge pclk);
    repeat (4) @(posedge pclk);
    // Frozen port must neither take the offered beat nor move the identifier
    ce       <= 1'b0;
    tx_valid <= 1'b1;
    tx_beat  <= b;
    repeat (4) @(posedge pclk);
    chk(32'({rx_valid, tx_ready, next_send_identifier}), 32'h41);
    ce       <= 1'b1;
    tx_valid <= 1'b0;
    @(posedge pclk);
    chk(32'(next_send_identifier), 32'h01);
    chk(32'(dropped), 32'h1);
    chk(32'(rw_cnt), 32'h1);
    apb(1'b0, 8'h10, 32'h0, rd, e);
    chk(rd, 32'({8'h01, 2'b11, tx_flow_control, local_buffer_status, 6'h01}));
    apb(1'b1, 8'h14, 32'hffff_ffff, rd, e);
    chk(32'({e, rd}), 32'h0) ;
    chk(32'(e), 32'h1);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, rd, e);
    chk(rd, 32'h10);
    report_and_stop();
  end
endmodule : pblp_port_tb
